/* logic/atp_pkg.sv */
// Package with register map, field layout and encodings of the async timer unit.
package atp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_TIMER_CONTROL_A = 8'hB0;
    localparam logic [7:0] ADDR_TIMER_CONTROL_B = 8'hB1;
    localparam logic [7:0] ADDR_COUNTER         = 8'hB2;
    localparam logic [7:0] ADDR_COMPARE_A       = 8'hB3;
    localparam logic [7:0] ADDR_COMPARE_B       = 8'hB4;
    localparam logic [7:0] ADDR_ASYNC_STATUS    = 8'hB6;
    localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'hB8;
    localparam logic [7:0] RESET_BYTE           = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTLA_MODE_A_HI = 7;
    localparam int CTLA_MODE_A_LO = 6;
    localparam int CTLA_MODE_B_HI = 5;
    localparam int CTLA_MODE_B_LO = 4;
    localparam int CTLA_WAVE_HI   = 1;
    localparam int CTLA_WAVE_LO   = 0;
    localparam int CTLB_FORCE_A   = 7;
    localparam int CTLB_FORCE_B   = 6;
    localparam int CTLB_WAVE_HIGH = 3;
    localparam int CTLB_CS_HI     = 2;
    localparam int CTLB_CS_LO     = 0;
    localparam int ASR_ASYNC_SEL  = 5;
    localparam int GCR_PRESC_RST  = 1;
    localparam logic [7:0] CTLA_WMASK = 8'hF3;
    localparam logic [7:0] CTLB_RMASK = 8'h0F;
    localparam logic [7:0] ASR_WMASK  = 8'h20;
    localparam logic [7:0] COUNT_TOP_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM  = 8'h00;
    localparam int         PRESC_W       = 10;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [2:0] {
        WAVE_NORMAL    = 3'h0,
        WAVE_PC_FF     = 3'h1,
        WAVE_CLR_MATCH = 3'h2,
        WAVE_FAST_FF   = 3'h3,
        WAVE_RSVD4     = 3'h4,
        WAVE_PC_OCA    = 3'h5,
        WAVE_RSVD6     = 3'h6,
        WAVE_FAST_OCA  = 3'h7
    } atp_wave_e;

    typedef enum logic [2:0] {
        CS_STOP  = 3'h0,
        CS_DIV1  = 3'h1,
        CS_DIV8  = 3'h2,
        CS_DIV32 = 3'h3,
        CS_DIV64 = 3'h4,
        CS_DIV128 = 3'h5,
        CS_DIV256 = 3'h6,
        CS_DIV1024 = 3'h7
    } atp_cs_e;

    typedef enum logic [1:0] {
        OM_OFF    = 2'h0,
        OM_TOGGLE = 2'h1,
        OM_CLEAR  = 2'h2,
        OM_SET    = 2'h3
    } atp_om_e;

    // Per-channel events presented to the waveform unit.
    typedef struct packed {
        logic match;
        logic force_strobe;
        logic at_bottom;
        logic at_top;
        logic top_equal;
    } atp_chan_ev_s;

    // Pin group for one crystal or compare pin.
    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
        logic port_detach;
    } atp_pin_s;

endpackage : atp_pkg

/* logic/atp_prescaler.sv */
// Prescaler of the async timer unit: divide counter and tap selection.
`timescale 1ns/1ps
module atp_prescaler (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Control
    input  wire logic                src_tick,
    input  wire logic                presc_clear,
    input  wire atp_pkg::atp_cs_e    clock_select,
    // Result
    output logic                     count_tick
);

    typedef struct packed {
        logic [atp_pkg::PRESC_W-1:0] div;
        logic                        tick;
    } atp_presc_s;

    atp_presc_s st;
    atp_presc_s next_st;
    logic [atp_pkg::PRESC_W-1:0] nxt_div;
    logic [atp_pkg::PRESC_W-1:0] wrap;

    // ************************************************************
    // Tap selection
    // ************************************************************
    always_comb begin
        nxt_div = st.div + atp_pkg::PRESC_W'(1);
        case (clock_select)
            atp_pkg::CS_DIV8:    wrap = atp_pkg::PRESC_W'(7);
            atp_pkg::CS_DIV32:   wrap = atp_pkg::PRESC_W'(31);
            atp_pkg::CS_DIV64:   wrap = atp_pkg::PRESC_W'(63);
            atp_pkg::CS_DIV128:  wrap = atp_pkg::PRESC_W'(127);
            atp_pkg::CS_DIV256:  wrap = atp_pkg::PRESC_W'(255);
            atp_pkg::CS_DIV1024: wrap = atp_pkg::PRESC_W'(1023);
            default:             wrap = '0;
        endcase
        next_st = st;
        next_st.tick = 1'b0;
        if (presc_clear) begin
            next_st.div = '0;
        end else if (src_tick && clock_select != atp_pkg::CS_STOP) begin
            next_st.div = nxt_div;
            // The tap fires on the source tick that completes a full division period.
            next_st.tick = (clock_select == atp_pkg::CS_DIV1) || ((st.div & wrap) == wrap);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count_tick = st.tick;

endmodule : atp_prescaler

/* logic/atp_timer.sv */
// Top of the async timer unit: APB registers, clock source, counter and compare outputs.
//
// Operation
// - Source clock is the I/O clock after reset; async select picks the crystal pin.
// - While async select is set, both crystal pins leave their port function.
// - Prescaler taps: undivided, /8, /32, /64, /128, /256, /1024, or stopped.
// - Writing one to prescaler reset clears the division counter.
// - Nonzero output mode gives the pin to the compare output, except PWM mode 01 on channel B or on A with waveform high bit zero; direction bit enables driver.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match, sets at bottom; 11 the opposite.
// - Channel A PWM mode 01 toggles on match only when waveform high bit is one.
// - Channel B PWM mode 01 is reserved; 10 and 11 behave as channel A.
// - Phase-correct: 10 clears on up match, sets on down match; 11 opposite.
// - Fast PWM with compare equal top and high mode bit: action at bottom only.
// - Phase-correct with compare equal top and high mode bit: action at top only.
// - Waveform field: 0 normal, 1 pc FF, 2 ctc, 3 fast FF, 5 pc A, 7 fast A.
// - Clock select 000 stop, 001 undivided, 010..111 /8 through /1024.
// - Force strobe in non-PWM applies output mode now, no counter clear, reads zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module atp_timer (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Crystal pins and port hand-over
    input  wire logic        crystal_in_pin,
    output logic             crystal_detach,
    // Direction bits of the pins carrying the compare outputs
    input  wire logic        dir_a,
    input  wire logic        dir_b,
    // Compare output pins
    output logic             compare_out_a,
    output logic             compare_out_a_oe_n,
    output logic             compare_a_override,
    output logic             compare_out_b,
    output logic             compare_out_b_oe_n,
    output logic             compare_b_override
);

    typedef struct packed {
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic       async_sel;
        logic       down;
        logic [1:0] xtal_sync;
        logic       xtal_prev;
        logic [1:0] oc;
        logic       force_a;
        logic       force_b;
        logic       presc_clr;
        logic [31:0] rdata;
    } atp_state_s;

    atp_state_s st;
    atp_state_s next_st;

    logic              wr_en;
    logic              rd_en;
    logic              addr_ok;
    logic [7:0]        wbyte;
    logic [7:0]        rbyte;
    logic              src_tick;
    logic              count_tick;
    atp_pkg::atp_wave_e wave;
    atp_pkg::atp_cs_e  csel;
    logic              pwm_fast;
    logic              pwm_pc;
    logic [7:0]        top;
    logic              at_top;
    logic              at_bottom;
    logic [1:0]        mode [2];
    logic [7:0]        cmpv [2];
    logic [1:0]        forcev;
    logic [1:0]        oc_next;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign wbyte  = pwdata[7:0];
    assign pready = 1'b1;
    assign prdata = st.rdata;

    always_comb begin
        addr_ok = 1'b1;
        rbyte   = atp_pkg::RESET_BYTE;
        if (paddr[31:8] != '0) begin
            addr_ok = 1'b0;
        end else if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_A) begin
            rbyte = st.ctl_a;
        end else if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_B) begin
            rbyte = st.ctl_b & atp_pkg::CTLB_RMASK;
        end else if (paddr[7:0] == atp_pkg::ADDR_COUNTER) begin
            rbyte = st.count;
        end else if (paddr[7:0] == atp_pkg::ADDR_COMPARE_A) begin
            rbyte = st.cmp_a;
        end else if (paddr[7:0] == atp_pkg::ADDR_COMPARE_B) begin
            rbyte = st.cmp_b;
        end else if (paddr[7:0] == atp_pkg::ADDR_ASYNC_STATUS) begin
            rbyte[atp_pkg::ASR_ASYNC_SEL] = st.async_sel;
        end else if (paddr[7:0] == atp_pkg::ADDR_GENERAL_CONTROL) begin
            rbyte = atp_pkg::RESET_BYTE;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = psel && penable && !addr_ok;

    // ************************************************************
    // Source clock and prescaler
    // ************************************************************
    // The crystal is sampled on pclk, so it must run well below half the bus rate.
    assign src_tick = st.async_sel ? (st.xtal_sync[1] && !st.xtal_prev) : 1'b1;
    assign crystal_detach = st.async_sel;
    assign csel = atp_pkg::atp_cs_e'(st.ctl_b[atp_pkg::CTLB_CS_HI:atp_pkg::CTLB_CS_LO]);

    atp_prescaler u_presc (
        .pclk         (pclk),
        .presetn      (presetn),
        .src_tick     (src_tick),
        .presc_clear  (st.presc_clr),
        .clock_select (csel),
        .count_tick   (count_tick)
    );

    // ************************************************************
    // Waveform mode decode
    // ************************************************************
    assign wave = atp_pkg::atp_wave_e'({st.ctl_b[atp_pkg::CTLB_WAVE_HIGH],
                                        st.ctl_a[atp_pkg::CTLA_WAVE_HI:atp_pkg::CTLA_WAVE_LO]});
    assign pwm_fast = (wave == atp_pkg::WAVE_FAST_FF) || (wave == atp_pkg::WAVE_FAST_OCA);
    assign pwm_pc   = (wave == atp_pkg::WAVE_PC_FF) || (wave == atp_pkg::WAVE_PC_OCA);
    always_comb begin
        case (wave)
            atp_pkg::WAVE_CLR_MATCH,
            atp_pkg::WAVE_PC_OCA,
            atp_pkg::WAVE_FAST_OCA: top = st.cmp_a;
            default:                top = atp_pkg::COUNT_TOP_MAX;
        endcase
    end
    assign at_top    = (st.count == top);
    assign at_bottom = (st.count == atp_pkg::COUNT_BOTTOM);
    assign mode[0] = st.ctl_a[atp_pkg::CTLA_MODE_A_HI:atp_pkg::CTLA_MODE_A_LO];
    assign mode[1] = st.ctl_a[atp_pkg::CTLA_MODE_B_HI:atp_pkg::CTLA_MODE_B_LO];
    assign cmpv[0] = st.cmp_a;
    assign cmpv[1] = st.cmp_b;
    assign forcev  = {st.force_b, st.force_a};

    // ************************************************************
    // Compare output per channel
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic match;
            logic top_eq;
            always_comb begin
                match  = count_tick && (st.count == cmpv[ch]);
                top_eq = (cmpv[ch] == top) && mode[ch][1];
                oc_next[ch] = st.oc[ch];
                if (!pwm_fast && !pwm_pc) begin
                    if (match || forcev[ch]) begin
                        case (atp_pkg::atp_om_e'(mode[ch]))
                            atp_pkg::OM_TOGGLE: oc_next[ch] = !st.oc[ch];
                            atp_pkg::OM_CLEAR:  oc_next[ch] = 1'b0;
                            atp_pkg::OM_SET:    oc_next[ch] = 1'b1;
                            default:            oc_next[ch] = st.oc[ch];
                        endcase
                    end
                end else if (mode[ch] == atp_pkg::OM_TOGGLE) begin
                    // Toggle only for channel A with the high waveform bit set.
                    if (ch == 0 && st.ctl_b[atp_pkg::CTLB_WAVE_HIGH] && match) begin
                        oc_next[ch] = !st.oc[ch];
                    end
                end else if (mode[ch][1]) begin
                    if (pwm_fast) begin
                        if (count_tick && at_top) begin
                            oc_next[ch] = !mode[ch][0];
                        end else if (match && !top_eq) begin
                            oc_next[ch] = mode[ch][0];
                        end
                    end else begin
                        if (top_eq) begin
                            if (count_tick && at_top) begin
                                oc_next[ch] = !mode[ch][0];
                            end
                        end else if (match) begin
                            oc_next[ch] = st.down ? !mode[ch][0] : mode[ch][0];
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // State update
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.xtal_sync = {st.xtal_sync[0], crystal_in_pin};
        next_st.xtal_prev = st.xtal_sync[1];
        next_st.force_a   = 1'b0;
        next_st.force_b   = 1'b0;
        next_st.presc_clr = 1'b0;
        next_st.oc        = oc_next;
        if (rd_en) begin
            next_st.rdata = {24'h000000, rbyte};
        end
        // Counter sequencing per waveform mode.
        if (count_tick) begin
            if (pwm_pc) begin
                if (!st.down && at_top) begin
                    next_st.down  = 1'b1;
                    next_st.count = st.count - 8'h01;
                end else if (st.down && at_bottom) begin
                    next_st.down  = 1'b0;
                    next_st.count = st.count + 8'h01;
                end else begin
                    next_st.count = st.down ? st.count - 8'h01 : st.count + 8'h01;
                end
            end else if (at_top && wave != atp_pkg::WAVE_NORMAL) begin
                next_st.count = atp_pkg::COUNT_BOTTOM;
            end else begin
                next_st.count = st.count + 8'h01;
            end
        end
        if (!pwm_pc) begin
            next_st.down = 1'b0;
        end
        if (wr_en && addr_ok) begin
            if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_A) begin
                next_st.ctl_a = wbyte & atp_pkg::CTLA_WMASK;
            end else if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_B) begin
                next_st.ctl_b   = wbyte & atp_pkg::CTLB_RMASK;
                next_st.force_a = wbyte[atp_pkg::CTLB_FORCE_A] && !pwm_fast && !pwm_pc;
                next_st.force_b = wbyte[atp_pkg::CTLB_FORCE_B] && !pwm_fast && !pwm_pc;
            end else if (paddr[7:0] == atp_pkg::ADDR_COUNTER) begin
                next_st.count = wbyte;
            end else if (paddr[7:0] == atp_pkg::ADDR_COMPARE_A) begin
                next_st.cmp_a = wbyte;
            end else if (paddr[7:0] == atp_pkg::ADDR_COMPARE_B) begin
                next_st.cmp_b = wbyte;
            end else if (paddr[7:0] == atp_pkg::ADDR_ASYNC_STATUS) begin
                next_st.async_sel = wbyte[atp_pkg::ASR_ASYNC_SEL];
            end else if (paddr[7:0] == atp_pkg::ADDR_GENERAL_CONTROL) begin
                next_st.presc_clr = wbyte[atp_pkg::GCR_PRESC_RST];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    assign compare_a_override = (mode[0] != atp_pkg::OM_OFF) && (!(pwm_fast || pwm_pc) ||
                                mode[0] != atp_pkg::OM_TOGGLE || st.ctl_b[atp_pkg::CTLB_WAVE_HIGH]);
    assign compare_b_override = (mode[1] != atp_pkg::OM_OFF) &&
                                (!(pwm_fast || pwm_pc) || mode[1] != atp_pkg::OM_TOGGLE);
    assign compare_out_a      = st.oc[0];
    assign compare_out_b      = st.oc[1];
    assign compare_out_a_oe_n = !(compare_a_override && dir_a);
    assign compare_out_b_oe_n = !(compare_b_override && dir_b);

endmodule : atp_timer

/* tb/atp_timer_assertions.sv */
// Checker of the async timer unit: pin hand-over, driver enables, forced actions and reset state.
`timescale 1ns/1ps
module atp_timer_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    // Pins
    input wire logic        crystal_detach,
    input wire logic        dir_a,
    input wire logic        dir_b,
    input wire logic        compare_out_a,
    input wire logic        compare_out_a_oe_n,
    input wire logic        compare_a_override,
    input wire logic        compare_out_b,
    input wire logic        compare_out_b_oe_n,
    input wire logic        compare_b_override
);
    // ************************************************************
    // Shadow of the control bits, taken at the APB write edge
    // ************************************************************
    logic       wr_en;
    logic       non_pwm;
    logic       async_sel;
    logic       touched;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    assign wr_en   = psel && penable && pwrite && paddr[31:8] == 24'h000000;
    assign non_pwm = !ctl_a[0] && !ctl_b[3];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_a     <= 8'h00;
            ctl_b     <= 8'h00;
            async_sel <= 1'b0;
            touched   <= 1'b0;
        end else if (wr_en) begin
            if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_A) begin
                ctl_a   <= pwdata[7:0];
                touched <= 1'b1;
            end
            if (paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_B) begin
                ctl_b <= pwdata[7:0];
            end
            if (paddr[7:0] == atp_pkg::ADDR_ASYNC_STATUS) begin
                async_sel <= pwdata[atp_pkg::ASR_ASYNC_SEL];
            end
        end
    end

    // A force write that leaves the waveform high bit and the clock selection at zero.
    sequence s_force_a_set;
        wr_en && paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_B && pwdata[7] && pwdata[3:0] == 4'h0
            && non_pwm && ctl_a[7:6] == 2'b11;
    endsequence
    sequence s_force_b_clear;
        wr_en && paddr[7:0] == atp_pkg::ADDR_TIMER_CONTROL_B && pwdata[6] && pwdata[3:0] == 4'h0
            && non_pwm && ctl_a[5:4] == 2'b10;
    endsequence

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_own_pin_a: assert property ((ctl_a[7:6] != 2'b01 || non_pwm) |->
        compare_a_override == (ctl_a[7:6] != 2'b00))
        else $error("channel A pin ownership wrong");
    a_own_pin_b: assert property ((ctl_a[5:4] != 2'b01 || non_pwm) |->
        compare_b_override == (ctl_a[5:4] != 2'b00))
        else $error("channel B pin ownership wrong");
    a_driver_a: assert property (compare_out_a_oe_n == !(compare_a_override && dir_a))
        else $error("channel A driver enable wrong");
    a_driver_b: assert property (compare_out_b_oe_n == !(compare_b_override && dir_b))
        else $error("channel B driver enable wrong");
    a_crystal_detach: assert property (crystal_detach == async_sel)
        else $error("crystal pins not handed over with async select");
    a_reset_quiet: assert property (!touched |-> !compare_out_a && !compare_out_b && compare_out_a_oe_n)
        else $error("compare outputs active before any output mode");
    a_force_set_a: assert property (s_force_a_set |-> ##[1:2] compare_out_a)
        else $error("forced set on channel A missing");
    a_force_clear_b: assert property (s_force_b_clear |-> ##[1:2] !compare_out_b)
        else $error("forced clear on channel B missing");
endmodule : atp_timer_sva

bind atp_timer atp_timer_sva sva_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .crystal_detach, .dir_a, .dir_b,
    .compare_out_a, .compare_out_a_oe_n, .compare_a_override,
    .compare_out_b, .compare_out_b_oe_n, .compare_b_override
);

/* tb/async_timer_prescale_compare_out_tb.sv */
// Self-checking bench of the async timer unit: registers, prescaler, clock source and compare outputs.
`timescale 1ns/1ps
module async_timer_prescale_compare_out_tb;
    localparam logic [7:0] CA        = atp_pkg::ADDR_TIMER_CONTROL_A;
    localparam logic [7:0] CB        = atp_pkg::ADDR_TIMER_CONTROL_B;
    localparam logic [7:0] CN        = atp_pkg::ADDR_COUNTER;
    localparam logic [7:0] GC        = atp_pkg::ADDR_GENERAL_CONTROL;
    localparam int         DIVS [8]  = '{0, 1, 8, 32, 64, 128, 256, 1024};
    localparam logic [7:0] PW_CA [7] = '{8'hA3, 8'hF3, 8'hA3, 8'hB1, 8'hB1, 8'h63, 8'h51};
    localparam logic [7:0] PW_CB [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h01};
    localparam logic [7:0] PW_OA [7] = '{8'h3F, 8'h3F, 8'hFF, 8'h40, 8'hFF, 8'h3F, 8'h40};
    localparam logic [7:0] PW_OB [7] = '{8'hBF, 8'hFF, 8'h7F, 8'h40, 8'hFF, 8'h1F, 8'h40};
    localparam int         PW_EA [7] = '{256, 768, 1024, 256, 1020, 512, -1};
    localparam int         PW_EB [7] = '{768, 0, 512, 764, 0, 512, -1};
    localparam logic [1:0] FM [4]    = '{2'b11, 2'b10, 2'b01, 2'b01};
    localparam logic       FE [4]    = '{1'b1, 1'b0, 1'b1, 1'b0};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [31:0] paddr, pwdata, prdata;
    logic        crystal_in_pin, crystal_detach, dir_a, dir_b;
    logic        compare_out_a, compare_out_a_oe_n, compare_a_override;
    logic        compare_out_b, compare_out_b_oe_n, compare_b_override;
    int          failures, checked, cyc;

    atp_timer dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .crystal_in_pin, .crystal_detach, .dir_a, .dir_b,
        .compare_out_a, .compare_out_a_oe_n, .compare_a_override,
        .compare_out_b, .compare_out_b_oe_n, .compare_b_override
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
    end
    // The crystal runs at an eighth of pclk, inside the margin the synchroniser needs.
    always begin
        repeat (4) @(posedge pclk);
        crystal_in_pin <= ~crystal_in_pin;
    end

    // ************************************************************
    // Bus cycles and comparisons
    // ************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {24'h000000, a};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q        = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic near(input string nm, input int lo, input int hi, input logic [15:0] g);
        checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0h", nm, lo, hi, g);
        end
    endtask : near
    task automatic chk_duty(input string nm, input int n, input int e, input int h);
        checked++;
        if (e < 0 ? (h != 0 && h != n) : (h < e - 6 || h > e + 6)) begin
            failures++;
            $display("BAD %s expected %0d seen %0d", nm, e, h);
        end
    endtask : chk_duty
    task automatic duty(input int n, output int ha, output int hb);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(negedge pclk);
            ha += int'(compare_out_a === 1'b1);
            hb += int'(compare_out_b === 1'b1);
        end
    endtask : duty
    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (80000) @(posedge pclk);
        failures++;
        test_done();
    end

    initial begin
        logic [7:0] q;
        int t0, n, ha, hb;
        {psel, penable, pwrite, paddr, pwdata, presetn, crystal_in_pin, dir_b} = '0;
        {failures, checked, cyc, last_err} = '0;
        dir_a = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CA, 8'h00, q);
        near("control a reset", 0, 0, {8'h00, q});
        wr(CA, 8'hFF);
        apb(1'b0, CA, 8'h00, q);
        near("control a mask", atp_pkg::CTLA_WMASK, atp_pkg::CTLA_WMASK, {8'h00, q});
        wr(CA, 8'h00);
        wr(CB, 8'hC0);
        apb(1'b0, CB, 8'h00, q);
        near("force bits read", 0, 0, {8'h00, q});
        apb(1'b0, 8'hB5, 8'h00, q);
        near("unmapped error", 1, 1, {15'h0000, last_err});
        wr(CB, 8'h00);
        wr(CN, 8'h55);
        repeat (64) @(posedge pclk);
        apb(1'b0, CN, 8'h00, q);
        near("stopped counter", 8'h55, 8'h55, {8'h00, q});
        for (int cs = 1; cs < 8; cs++) begin
            wr(CB, 8'h00);
            wr(CN, 8'h00);
            wr(GC, 8'h02);
            wr(CB, 8'(cs));
            t0 = cyc;
            repeat (16 * DIVS[cs]) @(posedge pclk);
            apb(1'b0, CN, 8'h00, q);
            n = (cyc - t0) / DIVS[cs];
            near("tap count", n - 4, n + 1, {8'h00, q});
        end
        wr(CB, 8'h00);
        wr(CN, 8'h00);
        wr(GC, 8'h02);
        wr(CB, 8'h07);
        repeat (900) @(posedge pclk);
        wr(GC, 8'h02);
        repeat (900) @(posedge pclk);
        apb(1'b0, CN, 8'h00, q);
        near("count after prescaler clear", 0, 0, {8'h00, q});
        wr(CB, 8'h00);
        wr(CN, 8'h00);
        wr(atp_pkg::ADDR_ASYNC_STATUS, 8'h20);
        wr(CB, 8'h01);
        t0 = cyc;
        repeat (160) @(posedge pclk);
        near("crystal detach", 1, 1, {15'h0000, crystal_detach});
        apb(1'b0, CN, 8'h00, q);
        n = (cyc - t0) / 8;
        near("crystal count", n - 3, n + 1, {8'h00, q});
        wr(CB, 8'h00);
        wr(atp_pkg::ADDR_ASYNC_STATUS, 8'h00);
        wr(CN, 8'h33);
        for (int i = 0; i < 4; i++) begin
            dir_b <= i[0];
            wr(CA, {FM[i], FM[i], 2'b00, i[0], 1'b0});
            wr(CB, 8'hC0);
            repeat (3) @(posedge pclk);
            near("forced a", FE[i], FE[i], {15'h0000, compare_out_a});
            near("forced b", FE[i], FE[i], {15'h0000, compare_out_b});
        end
        near("pin owner a", 1, 1, {15'h0000, compare_a_override});
        apb(1'b0, CN, 8'h00, q);
        near("counter kept", 8'h33, 8'h33, {8'h00, q});
        for (int k = 0; k < 7; k++) begin
            wr(atp_pkg::ADDR_COMPARE_A, PW_OA[k]);
            wr(atp_pkg::ADDR_COMPARE_B, PW_OB[k]);
            wr(CA, PW_CA[k]);
            wr(CB, PW_CB[k]);
            n = PW_CA[k][1] ? 1024 : 1020;
            repeat (600) @(posedge pclk);
            duty(n, ha, hb);
            chk_duty("duty a", n, PW_EA[k], ha);
            chk_duty("duty b", n, PW_EB[k], hb);
        end
        test_done();
    end
endmodule : async_timer_prescale_compare_out_tb
